// ### core/pcc_pkg.sv
// Purpose: shared constants and types for the second-loop calibration register bank
// Assumes: 250 MHz core clock, byte-wide register port behind the serial interface
// Notes: wait times are kept in their own units; cycle counts are derived here
package pcc_pkg;

    // ****************************************
    // clock and wait times
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned VCO_WAIT0_US = 20;
    localparam int unsigned VCO_WAIT1_US = 400;
    localparam int unsigned VCO_WAIT2_US = 8000;
    localparam int unsigned VCO_WAIT3_US = 200000;
    localparam int unsigned CLSD_WAIT0_US = 30;
    localparam int unsigned CLSD_WAIT1_US = 300;
    localparam int unsigned CLSD_WAIT2_US = 30000;
    localparam int unsigned CLSD_WAIT3_US = 300000;
    localparam int unsigned LBW_DELAY_US = 60000;
    localparam int unsigned VCO_WAIT0_CYC = VCO_WAIT0_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned VCO_WAIT1_CYC = VCO_WAIT1_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned VCO_WAIT2_CYC = VCO_WAIT2_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned VCO_WAIT3_CYC = VCO_WAIT3_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned CLSD_WAIT0_CYC = CLSD_WAIT0_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned CLSD_WAIT1_CYC = CLSD_WAIT1_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned CLSD_WAIT2_CYC = CLSD_WAIT2_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned CLSD_WAIT3_CYC = CLSD_WAIT3_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int unsigned LBW_DELAY_CYC = LBW_DELAY_US * NS_PER_US / CLK_PERIOD_NS;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OFS_PFD_PULSE_STRETCH_CTRL = 8'h83;
    localparam logic [7:0] OFS_LOOP_FILTER_ORDER_CTRL = 8'h84;
    localparam logic [7:0] OFS_CALIBRATION_WAIT_CTRL = 8'h85;
    localparam logic [7:0] OFS_CALIBRATION_DELAY_CTRL = 8'h86;
    localparam logic [7:0] OFS_STORED_CRC_BYTE = 8'h87;
    localparam logic [7:0] OFS_LIVE_CRC_BYTE = 8'h8a;
    localparam int unsigned POS_PULSE_STRETCH = 7;
    localparam int unsigned POS_LBW_DELAY = 0;
    localparam int unsigned POS_CLSD_WAIT = 2;
    localparam int unsigned POS_VCO_WAIT = 0;
    localparam logic [7:0] RST_PFD_PULSE_STRETCH_CTRL = 8'h00;
    localparam logic [2:0] RST_LOOP_FILTER_ORDER = 3'h3;
    localparam logic [1:0] RST_CLSD_WAIT = 2'h0;
    localparam logic [1:0] RST_VCO_WAIT = 2'h1;
    localparam logic [7:0] RST_CALIBRATION_DELAY_CTRL = 8'h00;
    localparam logic [7:0] RST_STORED_CRC = 8'h00;
    localparam logic [2:0] FILTER_ORDER_SECOND = 3'h3;
    localparam logic [2:0] FILTER_ORDER_THIRD = 3'h7;

    // ****************************************
    // crc
    // ****************************************
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // ****************************************
    // carriers and state
    // ****************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pcc_reg_req_t;

    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [7:0] addr;
        logic [7:0] data;
    } pcc_nvm_byte_t;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_LBW_DELAY,
        CAL_VCO_WAIT,
        CAL_CLSD_WAIT
    } pcc_cal_state_t;

    typedef struct packed {
        logic pulse_stretch_bit;
        logic [2:0] loop_filter_order_field;
        logic [1:0] closed_loop_wait_field;
        logic [1:0] vco_wait_field;
        logic loop_bandwidth_delay_bit;
        logic [7:0] stored_crc_value;
        logic [7:0] rdata;
        logic rvalid;
        logic store_pending;
        pcc_cal_state_t cal_state;
        logic [31:0] cal_cnt;
        logic [1:0] clsd_code;
        logic cal_done;
        logic cal_busy;
    } pcc_state_t;

    typedef struct packed {
        logic [7:0] crc;
    } pcc_crc_state_t;

endpackage : pcc_pkg

// ### core/pcc_crc8.sv
// Purpose: byte-serial crc accumulator over an nvm byte stream
// Assumes: stream bytes arrive on the core clock; first marks a new stream
// Notes: skip excludes a byte (the stored crc location) from the sum
`timescale 1ns/1ps
module pcc_crc8
    import pcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // byte stream
    input wire logic valid_in,
    input wire logic first_in,
    input wire logic skip_in,
    input wire logic [7:0] data_in,
    // result
    output logic [7:0] crc_out
);

    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
        logic [7:0] c;
        c = crc ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction : crc_step

    pcc_crc_state_t st_reg;
    pcc_crc_state_t st_next;

    always_comb begin
        logic [7:0] seed;
        seed = first_in ? CRC_INIT : st_reg.crc;
        st_next = st_reg;
        if (valid_in) begin
            st_next.crc = skip_in ? seed : crc_step(seed, data_in);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_reg.crc <= CRC_INIT;
        end else begin
            st_reg <= st_next;
        end
    end

    assign crc_out = st_reg.crc;

endmodule : pcc_crc8

// ### core/pcc_regs.sv
// Purpose: second-loop control registers, calibration wait sequencer, nvm crc
// Assumes: register port and nvm streams are on clk_in; times as in pcc_pkg
// Notes: long waits are parameters so simulation can shorten them
`timescale 1ns/1ps
// Behaviour
// - stretch bit picks 200 or 600 ps
// - filter field: 0x3 second, 0x7 third order
// - closed-loop wait code selects 30us..300ms
// - oscillator wait code selects 20us..200ms, resets 1
// - delay bit adds 60 ms before calibration
// - programming computes crc into stored byte
// - crc skips the stored crc byte
// - nvm restores filter, waits, delay bit and stored crc
// - stored crc takes the program crc only when auto enabled
// - live crc computed on nvm read
module pcc_regs
    import pcc_pkg::*;
#(
    parameter int unsigned VCO_C0 = VCO_WAIT0_CYC,
    parameter int unsigned VCO_C1 = VCO_WAIT1_CYC,
    parameter int unsigned VCO_C2 = VCO_WAIT2_CYC,
    parameter int unsigned VCO_C3 = VCO_WAIT3_CYC,
    parameter int unsigned CLSD_C0 = CLSD_WAIT0_CYC,
    parameter int unsigned CLSD_C1 = CLSD_WAIT1_CYC,
    parameter int unsigned CLSD_C2 = CLSD_WAIT2_CYC,
    parameter int unsigned CLSD_C3 = CLSD_WAIT3_CYC,
    parameter int unsigned LBW_C = LBW_DELAY_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // register port
    input wire pcc_reg_req_t reg_req_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // nvm streams
    input wire pcc_nvm_byte_t nvm_prog_in,
    input wire pcc_nvm_byte_t nvm_read_in,
    input wire logic auto_crc_enable_in,
    // calibration
    input wire logic cal_start_in,
    output logic cal_busy_out,
    output logic cal_done_out,
    output pcc_cal_state_t cal_phase_out,
    // analog controls
    output logic pulse_stretch_out,
    output logic [2:0] loop_filter_order_out
);

    // ****************************************
    // wait lookups
    // ****************************************
    function automatic logic [31:0] vco_cycles(input logic [1:0] code);
        case (code)
            2'h0: return 32'(VCO_C0);
            2'h1: return 32'(VCO_C1);
            2'h2: return 32'(VCO_C2);
            default: return 32'(VCO_C3);
        endcase
    endfunction : vco_cycles

    function automatic logic [31:0] clsd_cycles(input logic [1:0] code);
        case (code)
            2'h0: return 32'(CLSD_C0);
            2'h1: return 32'(CLSD_C1);
            2'h2: return 32'(CLSD_C2);
            default: return 32'(CLSD_C3);
        endcase
    endfunction : clsd_cycles

    pcc_state_t st_reg;
    pcc_state_t st_next;
    logic [7:0] prog_crc;
    logic [7:0] live_crc;

    // ****************************************
    // crc engines
    // ****************************************
    pcc_crc8 u_prog_crc (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .valid_in(nvm_prog_in.valid),
        .first_in(nvm_prog_in.first),
        .skip_in(nvm_prog_in.addr == OFS_STORED_CRC_BYTE),
        .data_in(nvm_prog_in.data),
        .crc_out(prog_crc)
    );

    pcc_crc8 u_live_crc (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .valid_in(nvm_read_in.valid),
        .first_in(nvm_read_in.first),
        .skip_in(nvm_read_in.addr == OFS_STORED_CRC_BYTE),
        .data_in(nvm_read_in.data),
        .crc_out(live_crc)
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        st_next = st_reg;
        st_next.rvalid = reg_req_in.rd;
        st_next.cal_done = 1'b0;
        st_next.rdata = 8'h00;
        if (reg_req_in.rd) begin
            case (reg_req_in.addr)
                OFS_PFD_PULSE_STRETCH_CTRL: st_next.rdata = {st_reg.pulse_stretch_bit, 7'h00};
                OFS_LOOP_FILTER_ORDER_CTRL: st_next.rdata = {5'h00, st_reg.loop_filter_order_field};
                OFS_CALIBRATION_WAIT_CTRL:
                    st_next.rdata = {4'h0, st_reg.closed_loop_wait_field, st_reg.vco_wait_field};
                OFS_CALIBRATION_DELAY_CTRL: st_next.rdata = {7'h00, st_reg.loop_bandwidth_delay_bit};
                OFS_STORED_CRC_BYTE: st_next.rdata = st_reg.stored_crc_value;
                OFS_LIVE_CRC_BYTE: st_next.rdata = live_crc;
                default: st_next.rdata = 8'h00;
            endcase
        end
        // restore from nvm; stretch bit is volatile
        if (nvm_read_in.valid) begin
            case (nvm_read_in.addr)
                OFS_LOOP_FILTER_ORDER_CTRL: st_next.loop_filter_order_field = nvm_read_in.data[2:0];
                OFS_CALIBRATION_WAIT_CTRL: begin
                    st_next.closed_loop_wait_field = nvm_read_in.data[POS_CLSD_WAIT +: 2];
                    st_next.vco_wait_field = nvm_read_in.data[POS_VCO_WAIT +: 2];
                end
                OFS_CALIBRATION_DELAY_CTRL:
                    st_next.loop_bandwidth_delay_bit = nvm_read_in.data[POS_LBW_DELAY];
                OFS_STORED_CRC_BYTE: st_next.stored_crc_value = nvm_read_in.data;
                default: ;
            endcase
        end
        // software write wins over a restore in the same cycle
        if (reg_req_in.wr) begin
            case (reg_req_in.addr)
                OFS_PFD_PULSE_STRETCH_CTRL:
                    st_next.pulse_stretch_bit = reg_req_in.wdata[POS_PULSE_STRETCH];
                OFS_LOOP_FILTER_ORDER_CTRL: st_next.loop_filter_order_field = reg_req_in.wdata[2:0];
                OFS_CALIBRATION_WAIT_CTRL: begin
                    st_next.closed_loop_wait_field = reg_req_in.wdata[POS_CLSD_WAIT +: 2];
                    st_next.vco_wait_field = reg_req_in.wdata[POS_VCO_WAIT +: 2];
                end
                OFS_CALIBRATION_DELAY_CTRL:
                    st_next.loop_bandwidth_delay_bit = reg_req_in.wdata[POS_LBW_DELAY];
                default: ;
            endcase
        end
        // crc result lands two cycles after the last programmed byte
        st_next.store_pending = nvm_prog_in.valid && nvm_prog_in.last && auto_crc_enable_in;
        if (st_reg.store_pending) begin
            st_next.stored_crc_value = prog_crc;
        end
        // calibration sequencer
        case (st_reg.cal_state)
            CAL_IDLE: begin
                if (cal_start_in) begin
                    st_next.clsd_code = st_reg.closed_loop_wait_field;
                    if (st_reg.loop_bandwidth_delay_bit) begin
                        st_next.cal_state = CAL_LBW_DELAY;
                        st_next.cal_cnt = 32'(LBW_C) - 32'd1;
                    end else begin
                        st_next.cal_state = CAL_VCO_WAIT;
                        st_next.cal_cnt = vco_cycles(st_reg.vco_wait_field) - 32'd1;
                    end
                end
            end
            CAL_LBW_DELAY: begin
                if (st_reg.cal_cnt == 32'd0) begin
                    st_next.cal_state = CAL_VCO_WAIT;
                    st_next.cal_cnt = vco_cycles(st_reg.vco_wait_field) - 32'd1;
                end else begin
                    st_next.cal_cnt = st_reg.cal_cnt - 32'd1;
                end
            end
            CAL_VCO_WAIT: begin
                if (st_reg.cal_cnt == 32'd0) begin
                    st_next.cal_state = CAL_CLSD_WAIT;
                    st_next.cal_cnt = clsd_cycles(st_reg.clsd_code) - 32'd1;
                end else begin
                    st_next.cal_cnt = st_reg.cal_cnt - 32'd1;
                end
            end
            CAL_CLSD_WAIT: begin
                if (st_reg.cal_cnt == 32'd0) begin
                    st_next.cal_state = CAL_IDLE;
                    st_next.cal_done = 1'b1;
                end else begin
                    st_next.cal_cnt = st_reg.cal_cnt - 32'd1;
                end
            end
            default: st_next.cal_state = CAL_IDLE;
        endcase
        // busy kept in a flop so the pin never sees decode glitches
        st_next.cal_busy = (st_next.cal_state != CAL_IDLE);
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            st_reg.pulse_stretch_bit <= RST_PFD_PULSE_STRETCH_CTRL[POS_PULSE_STRETCH];
            st_reg.loop_filter_order_field <= RST_LOOP_FILTER_ORDER;
            st_reg.closed_loop_wait_field <= RST_CLSD_WAIT;
            st_reg.vco_wait_field <= RST_VCO_WAIT;
            st_reg.loop_bandwidth_delay_bit <= RST_CALIBRATION_DELAY_CTRL[POS_LBW_DELAY];
            st_reg.stored_crc_value <= RST_STORED_CRC;
            st_reg.rdata <= 8'h00;
            st_reg.rvalid <= 1'b0;
            st_reg.store_pending <= 1'b0;
            st_reg.cal_state <= CAL_IDLE;
            st_reg.cal_cnt <= 32'd0;
            st_reg.clsd_code <= RST_CLSD_WAIT;
            st_reg.cal_done <= 1'b0;
            st_reg.cal_busy <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_out = st_reg.rdata;
    assign reg_rvalid_out = st_reg.rvalid;
    assign pulse_stretch_out = st_reg.pulse_stretch_bit;
    assign loop_filter_order_out = st_reg.loop_filter_order_field;
    assign cal_busy_out = st_reg.cal_busy;
    assign cal_done_out = st_reg.cal_done;
    assign cal_phase_out = st_reg.cal_state;

    // ****************************************
    // checks
    // ****************************************
    sequence s_wr(logic [7:0] a);
        reg_req_in.wr && reg_req_in.addr == a && !srst_in;
    endsequence

    property p_stretch_wr;
        @(posedge clk_in) disable iff (srst_in)
        s_wr(OFS_PFD_PULSE_STRETCH_CTRL) |=> pulse_stretch_out == $past(reg_req_in.wdata[7]);
    endproperty
    a_stretch_wr: assert property (p_stretch_wr) else $error("stretch bit not written");

    property p_order_wr;
        @(posedge clk_in) disable iff (srst_in)
        s_wr(OFS_LOOP_FILTER_ORDER_CTRL) |=> loop_filter_order_out == $past(reg_req_in.wdata[2:0]);
    endproperty
    a_order_wr: assert property (p_order_wr) else $error("filter order not written");

    property p_no_delay;
        @(posedge clk_in) disable iff (srst_in)
        (cal_phase_out == CAL_IDLE && cal_start_in && !st_reg.loop_bandwidth_delay_bit)
            |=> cal_phase_out == CAL_VCO_WAIT;
    endproperty
    a_no_delay: assert property (p_no_delay) else $error("delay taken with bit clear");

    property p_delay;
        @(posedge clk_in) disable iff (srst_in)
        (cal_phase_out == CAL_IDLE && cal_start_in && st_reg.loop_bandwidth_delay_bit)
            |=> cal_phase_out == CAL_LBW_DELAY && st_reg.cal_cnt == 32'(LBW_C) - 32'd1;
    endproperty
    a_delay: assert property (p_delay) else $error("delay not started");

    property p_order_seq;
        @(posedge clk_in) disable iff (srst_in)
        (cal_phase_out != $past(cal_phase_out) && cal_phase_out == CAL_CLSD_WAIT)
            |-> $past(cal_phase_out) == CAL_VCO_WAIT;
    endproperty
    a_order_seq: assert property (p_order_seq) else $error("closed-loop wait entered early");

    property p_clsd_len;
        @(posedge clk_in) disable iff (srst_in)
        ($rose(cal_phase_out == CAL_CLSD_WAIT)) |-> st_reg.cal_cnt == clsd_cycles(st_reg.clsd_code) - 32'd1;
    endproperty
    a_clsd_len: assert property (p_clsd_len) else $error("closed-loop wait length wrong");

    property p_crc_off;
        @(posedge clk_in) disable iff (srst_in)
        (nvm_prog_in.valid && nvm_prog_in.last && !auto_crc_enable_in && !nvm_read_in.valid)
            |=> ##1 st_reg.stored_crc_value == $past(st_reg.stored_crc_value, 2);
    endproperty
    a_crc_off: assert property (p_crc_off) else $error("stored crc changed while auto off");

    property p_crc_on;
        @(posedge clk_in) disable iff (srst_in)
        (nvm_prog_in.valid && nvm_prog_in.last && auto_crc_enable_in) |=> ##1 st_reg.stored_crc_value == $past(prog_crc);
    endproperty
    a_crc_on: assert property (p_crc_on) else $error("stored crc not taken from program");

    property p_no_restore_stretch;
        @(posedge clk_in) disable iff (srst_in)
        (nvm_read_in.valid && !reg_req_in.wr) |=> pulse_stretch_out == $past(pulse_stretch_out);
    endproperty
    a_no_restore_stretch: assert property (p_no_restore_stretch) else $error("stretch bit restored");

endmodule : pcc_regs

// ### dv/tb.sv
// Purpose: self-checking bench for the second-loop calibration register bank
// Assumes: byte request port and nvm byte streams driven directly, short wait parameters
// Notes: expected crc and phase lengths are worked out here, never read back from the design
`timescale 1ns/1ps
module tb
    import pcc_pkg::*;
;
    // ****************************************
    // clock, reset, stimulus
    // ****************************************
    localparam int unsigned VC [4] = '{2, 3, 4, 5};
    localparam int unsigned CC [4] = '{3, 4, 5, 6};
    localparam int unsigned LBW = 7;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    pcc_reg_req_t reg_req = '0;
    pcc_nvm_byte_t nvm_prog = '0;
    pcc_nvm_byte_t nvm_read = '0;
    logic auto_crc = 1'b0;
    logic cal_start = 1'b0;
    logic [7:0] rdata;
    logic rvalid;
    logic busy;
    logic done;
    pcc_cal_state_t phase;
    logic stretch;
    logic [2:0] filter;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] exp_crc;

    always #2 clk_in = ~clk_in;

    pcc_regs #(.VCO_C0(VC[0]), .VCO_C1(VC[1]), .VCO_C2(VC[2]), .VCO_C3(VC[3]),
        .CLSD_C0(CC[0]), .CLSD_C1(CC[1]), .CLSD_C2(CC[2]), .CLSD_C3(CC[3]), .LBW_C(LBW)) u_dut (
        .clk_in(clk_in), .srst_in(srst_in), .reg_req_in(reg_req), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .nvm_prog_in(nvm_prog), .nvm_read_in(nvm_read),
        .auto_crc_enable_in(auto_crc), .cal_start_in(cal_start), .cal_busy_out(busy),
        .cal_done_out(done), .cal_phase_out(phase), .pulse_stretch_out(stretch),
        .loop_filter_order_out(filter));

    // ****************************************
    // helpers
    // ****************************************
    task automatic summarize();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            summarize();
        end
    end

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : crc_step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk_in);
        reg_req <= '0;
    endtask : wr

    // read answer is registered one edge after the request is driven
    task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_in);
        reg_req <= '0;
        #1;
        check({name, " valid"}, 8'h01, {7'h00, rvalid});
        check(name, exp, rdata);
    endtask : rd

    task automatic nvm(input logic prog, input logic f, input logic l, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        if (prog) begin
            nvm_prog <= '{1'b1, f, l, a, d};
        end else begin
            nvm_read <= '{1'b1, f, l, a, d};
        end
        @(posedge clk_in);
        nvm_prog <= '0;
        nvm_read <= '0;
    endtask : nvm

    // counts cycles spent in each phase; a second start while busy must be ignored
    task automatic cal(input logic dly, input logic [1:0] oscillator_core, input logic [1:0] clsd);
        int p1;
        int p2;
        int p3;
        int dn;
        int bz;
        p1 = 0;
        p2 = 0;
        p3 = 0;
        dn = 0;
        bz = 0;
        wr(8'h86, {7'h00, dly});
        wr(8'h85, {4'h0, clsd, oscillator_core});
        @(posedge clk_in);
        cal_start <= 1'b1;
        for (int n = 0; n < 200; n++) begin
            @(posedge clk_in);
            cal_start <= (n == 1);
            #1;
            if (phase === CAL_LBW_DELAY) p1++;
            if (phase === CAL_VCO_WAIT) p2++;
            if (phase === CAL_CLSD_WAIT) p3++;
            if (busy === 1'b1) bz++;
            if (done === 1'b1) begin
                dn++;
                break;
            end
        end
        check("delay phase", dly ? 8'(LBW) : 8'h00, 8'(p1));
        check("osc phase", 8'(VC[oscillator_core]), 8'(p2));
        check("closed phase", 8'(CC[clsd]), 8'(p3));
        check("done pulse", 8'h01, 8'(dn));
        check("busy after", 8'h00, {7'h00, busy});
        check("busy cycles", 8'((dly ? LBW : 0) + VC[oscillator_core] + CC[clsd]), 8'(bz));
    endtask : cal

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        rd("stretch rst", 8'h83, 8'h00);
        rd("filter rst", 8'h84, 8'h03);
        rd("wait rst", 8'h85, 8'h01);
        rd("delay rst", 8'h86, 8'h00);
        rd("scrc rst", 8'h87, 8'h00);
        rd("lcrc rst", 8'h8a, 8'h00);
        check("filter out rst", 8'h03, {5'h00, filter});
        wr(8'h83, 8'hff);
        rd("stretch set", 8'h83, 8'h80);
        check("stretch out", 8'h01, {7'h00, stretch});
        wr(8'h84, 8'hff);
        rd("filter set", 8'h84, 8'h07);
        check("filter out", 8'h07, {5'h00, filter});
        wr(8'h85, 8'hff);
        rd("wait set", 8'h85, 8'h0f);
        wr(8'h86, 8'hff);
        rd("delay set", 8'h86, 8'h01);
        wr(8'h87, 8'h5a);
        rd("scrc ro", 8'h87, 8'h00);
        wr(8'h90, 8'h5a);
        rd("unmapped", 8'h90, 8'h00);
        // program stream with auto crc: stored byte excluded from the sum
        auto_crc <= 1'b1;
        exp_crc = crc_step(crc_step(crc_step(8'h00, 8'h07), 8'h06), 8'h01);
        nvm(1'b1, 1'b1, 1'b0, 8'h84, 8'h07);
        nvm(1'b1, 1'b0, 1'b0, 8'h85, 8'h06);
        nvm(1'b1, 1'b0, 1'b0, 8'h87, 8'h5a);
        nvm(1'b1, 1'b0, 1'b1, 8'h86, 8'h01);
        rd("scrc prog", 8'h87, exp_crc);
        auto_crc <= 1'b0;
        nvm(1'b1, 1'b1, 1'b1, 8'h84, 8'h03);
        rd("scrc hold", 8'h87, exp_crc);
        // restore from nvm read: stretch bit must keep its own value
        wr(8'h83, 8'h00);
        wr(8'h84, 8'h03);
        wr(8'h85, 8'h00);
        wr(8'h86, 8'h00);
        nvm(1'b0, 1'b1, 1'b0, 8'h83, 8'h80);
        nvm(1'b0, 1'b0, 1'b0, 8'h84, 8'h07);
        nvm(1'b0, 1'b0, 1'b0, 8'h85, 8'h0b);
        nvm(1'b0, 1'b0, 1'b0, 8'h87, 8'h3c);
        nvm(1'b0, 1'b0, 1'b1, 8'h86, 8'h01);
        exp_crc = crc_step(crc_step(crc_step(crc_step(8'h00, 8'h80), 8'h07), 8'h0b), 8'h01);
        rd("no restore", 8'h83, 8'h00);
        rd("filter rest", 8'h84, 8'h07);
        rd("wait rest", 8'h85, 8'h0b);
        rd("delay rest", 8'h86, 8'h01);
        rd("live crc", 8'h8a, exp_crc);
        rd("scrc rest", 8'h87, 8'h3c);
        for (int i = 0; i < 4; i++) begin
            cal(i[0], 2'(i), 2'(3 - i));
        end
        // mid-run reset drops a running calibration and the registers
        wr(8'h86, 8'h01);
        @(posedge clk_in);
        cal_start <= 1'b1;
        @(posedge clk_in);
        cal_start <= 1'b0;
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        srst_in <= 1'b0;
        #1;
        check("phase rst", 8'h00, {6'h00, phase});
        check("busy rst", 8'h00, {7'h00, busy});
        rd("delay rerst", 8'h86, 8'h00);
        rd("wait rerst", 8'h85, 8'h01);
        rd("scrc rerst", 8'h87, 8'h00);
        summarize();
    end
endmodule : tb
